// ---- bench/oip_chk.sv ----
`timescale 1ns/100ps
`include "oip_defines.svh"

module oip_chk (
    input wire logic        I_MCLK,
    input wire logic        I_RST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic        I_TRIG,
    input wire logic [15:0] I_MEAS_CURR,
    input wire logic [15:0] I_MEAS_CURR2,
    input wire logic        O_OUT_EN,
    input wire logic [15:0] O_CURR_SET,
    input wire logic [15:0] O_AUX_CURRENT_SETPOINT,
    input wire logic        O_OVERCURRENT_FLAG,
    input wire logic        O_FAULT_INDICATOR_OUT,
    input wire logic        O_PIN1,
    input wire logic        O_PIN3_OE
);
    logic wr_t;
    logic cc_any;
    assign wr_t = I_PSEL && I_PENABLE && I_PWRITE;
    assign cc_any = (I_MEAS_CURR >= O_CURR_SET)
        || (I_MEAS_CURR2 >= O_AUX_CURRENT_SETPOINT);

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    // ****************************************
    // protection
    // ****************************************
    a_oc_cuts_out: assert property (
        $rose(O_OVERCURRENT_FLAG) |=> !O_OUT_EN)
        else $error("output still on after overcurrent");
    a_oc_cause: assert property (
        $rose(O_OVERCURRENT_FLAG) |-> $past(O_OUT_EN && cc_any))
        else $error("overcurrent flag without cause");
    a_oc_clear_needs: assert property (
        $fell(O_OVERCURRENT_FLAG) |-> $past(wr_t && I_PWDATA[0]
            && I_PADDR == `OIP_A_CMD && !cc_any))
        else $error("overcurrent flag cleared wrongly");
    a_fault_flag: assert property (
        O_OVERCURRENT_FLAG |-> O_FAULT_INDICATOR_OUT)
        else $error("fault output low with flag set");

    // ****************************************
    // setpoints
    // ****************************************
    a_curr_write: assert property (
        wr_t && I_PADDR == `OIP_A_CURR && !I_TRIG
        |=> O_CURR_SET == $past(I_PWDATA[15:0]))
        else $error("main setpoint not written");
    a_aux_indep: assert property (
        wr_t && I_PADDR == `OIP_A_CURR && !I_TRIG
        |=> $stable(O_AUX_CURRENT_SETPOINT))
        else $error("aux setpoint moved on main write");
    a_set_cause: assert property (
        $changed(O_CURR_SET) |-> $past(I_TRIG || wr_t
            && (I_PADDR == `OIP_A_CURR || I_PADDR == `OIP_A_CMD)))
        else $error("main setpoint changed without cause");

    // ****************************************
    // control port
    // ****************************************
    a_port_bit2: assert property (
        wr_t && I_PADDR == `OIP_A_PORT && I_PWDATA[2] |=> !O_PIN3_OE)
        else $error("pin 3 driven while set as input");
    a_pin_data: assert property (
        $changed(O_PIN1) && $past(wr_t && I_PADDR == `OIP_A_PORT)
        |-> O_PIN1 == $past(I_PWDATA[0]))
        else $error("pin 1 differs from data bit 0");
endmodule

bind oip_core oip_chk u_chk (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_TRIG(I_TRIG),
    .I_MEAS_CURR(I_MEAS_CURR), .I_MEAS_CURR2(I_MEAS_CURR2),
    .O_OUT_EN(O_OUT_EN), .O_CURR_SET(O_CURR_SET),
    .O_AUX_CURRENT_SETPOINT(O_AUX_CURRENT_SETPOINT),
    .O_OVERCURRENT_FLAG(O_OVERCURRENT_FLAG),
    .O_FAULT_INDICATOR_OUT(O_FAULT_INDICATOR_OUT),
    .O_PIN1(O_PIN1), .O_PIN3_OE(O_PIN3_OE));

// ---- bench/oip_ctl_model.sv ----
`timescale 1ns/100ps

module oip_ctl_model (
    input  wire logic       i_clk,
    input  wire logic       i_inh_req,
    input  wire logic       i_p3_level,
    input  wire logic       i_pin3,
    input  wire logic       i_pin3_oe,
    input  wire logic       i_nv_wr,
    input  wire logic [1:0] i_nv_mode,
    output logic            o_inhibit_n,
    output logic            o_pin3_wire,
    output logic      [1:0] o_nv_mode
);
    logic [1:0] nv_cell_reg = 2'h0;
    assign o_inhibit_n = !i_inh_req;
    // the controller only drives pin 3 while the block has let go of it
    assign o_pin3_wire = i_pin3_oe ? i_pin3 : i_p3_level;
    assign o_nv_mode = nv_cell_reg;
    // cell survives the block's reset, as stored mode must
    always @(posedge i_clk) begin
        if (i_nv_wr === 1'b1) begin
            nv_cell_reg <= i_nv_mode;
        end
    end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`include "oip_defines.svh"

module testbench;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic trig = 1'b0, inh_req = 1'b0, p3_level = 1'b0, se;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [15:0] meas = 16'h0, meas2 = 16'h0, curr_set, aux_set;
    logic [31:0] prdata;
    logic [1:0] nv_o, nv_i;
    logic [3:0] v;
    logic pready, pslverr, nv_wr, out_en, oc_flag, fault, inh_n;
    logic pin1, pin2, pin3_o, pin3_oe, pin3_w;
    int err_count = 0, check_count = 0, cyc = 0;

    always #20 clk = ~clk;

    oip_core #(.P_PROT_DLY_CYC(20)) dut (.I_MCLK(clk), .I_RST(rst),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_INHIBIT_INPUT_N(inh_n), .I_TRIG(trig),
        .I_MEAS_CURR(meas), .I_MEAS_CURR2(meas2), .I_NV_MODE(nv_i),
        .O_NV_WR(nv_wr), .O_NV_MODE(nv_o), .O_OUT_EN(out_en),
        .O_CURR_SET(curr_set), .O_AUX_CURRENT_SETPOINT(aux_set),
        .O_OVERCURRENT_FLAG(oc_flag), .O_FAULT_INDICATOR_OUT(fault),
        .O_PIN1(pin1), .O_PIN2(pin2), .I_PIN3(pin3_w), .O_PIN3(pin3_o),
        .O_PIN3_OE(pin3_oe));

    oip_ctl_model u_ctl (.i_clk(clk), .i_inh_req(inh_req),
        .i_p3_level(p3_level), .i_pin3(pin3_o), .i_pin3_oe(pin3_oe),
        .i_nv_wr(nv_wr), .i_nv_mode(nv_o), .o_inhibit_n(inh_n),
        .o_pin3_wire(pin3_w), .o_nv_mode(nv_i));

    // ****************************************
    // tasks
    // ****************************************
    task conclude;
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // idle cycle between transfers keeps every strobe to one change a step
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd_chk(input string what, input logic [7:0] a,
                input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task inhibit_input(input logic lvl);
        @(posedge clk);
        inh_req <= lvl;
        settle(5);
    endtask

    task pulse;
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            conclude();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk("curr", {16'h0, curr_set}, 32'h1999);
        chk("aux", {16'h0, aux_set}, 32'h1999);
        rd_chk("curr_reg", `OIP_A_CURR, 32'h1999);
        chk("pins", {29'h0, pin3_oe, pin2, pin1}, 32'h0);
        $display("test reset finished");
        wr(`OIP_A_CTRL, 32'h12);
        settle(1);
        chk("out_on", 32'(out_en), 32'h1);
        inhibit_input(1'b1);
        chk("latch_low", 32'(out_en), 32'h0);
        chk("fault_latch", 32'(fault), 32'h1);
        wr(`OIP_A_CMD, 32'h1);
        settle(2);
        chk("clr_active", 32'(out_en), 32'h0);
        inhibit_input(1'b0);
        chk("latch_kept", 32'(out_en), 32'h0);
        wr(`OIP_A_CMD, 32'h1);
        settle(1);
        chk("latch_clr", 32'(out_en), 32'h1);
        wr(`OIP_A_CTRL, 32'h11);
        inhibit_input(1'b1);
        chk("live_low", 32'(out_en), 32'h0);
        inhibit_input(1'b0);
        chk("live_high", 32'(out_en), 32'h1);
        wr(`OIP_A_CTRL, 32'h10);
        inhibit_input(1'b1);
        chk("off_low", 32'(out_en), 32'h1);
        inhibit_input(1'b0);
        $display("test inhibit finished");
        wr(`OIP_A_CTRL, 32'h12);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(2);
        rd_chk("mode_kept", `OIP_A_CTRL, 32'h2);
        wr(`OIP_A_CTRL, 32'h10);
        $display("test storage finished");
        wr(`OIP_A_CURR, 32'h0100);
        @(posedge clk);
        meas <= 16'h0100;
        wr(`OIP_A_CTRL, 32'h14);
        settle(1);
        chk("oc_delay", 32'(oc_flag), 32'h0);
        settle(30);
        chk("oc_trip", 32'(oc_flag), 32'h1);
        chk("oc_off", 32'(out_en), 32'h0);
        wr(`OIP_A_CMD, 32'h1);
        settle(1);
        chk("oc_cause", 32'(oc_flag), 32'h1);
        @(posedge clk);
        meas <= 16'h0;
        wr(`OIP_A_CMD, 32'h1);
        settle(1);
        chk("oc_clr", 32'(oc_flag), 32'h0);
        chk("oc_restore", 32'(out_en), 32'h1);
        @(posedge clk);
        meas2 <= 16'h2000;
        settle(30);
        chk("oc_aux", 32'(oc_flag), 32'h1);
        @(posedge clk);
        meas2 <= 16'h0;
        wr(`OIP_A_CMD, 32'h1);
        wr(`OIP_A_CTRL, 32'h10);
        @(posedge clk);
        meas <= 16'hffff;
        settle(30);
        chk("oc_disabled", 32'(oc_flag), 32'h0);
        $display("test overcurrent finished");
        wr(`OIP_A_CURR2, 32'h0777);
        settle(1);
        chk("aux_wr", {16'h0, aux_set}, 32'h0777);
        chk("main_kept", {16'h0, curr_set}, 32'h0100);
        wr(`OIP_A_CURRT, 32'h0aaa);
        wr(`OIP_A_CURR2T, 32'h0555);
        pulse();
        settle(1);
        chk("unarmed", {16'h0, curr_set}, 32'h0100);
        wr(`OIP_A_CMD, 32'h2);
        pulse();
        settle(1);
        chk("trig_main", {16'h0, curr_set}, 32'h0aaa);
        chk("trig_aux", {16'h0, aux_set}, 32'h0555);
        wr(`OIP_A_CURRT, 32'h0123);
        wr(`OIP_A_CMD, 32'h4);
        settle(1);
        chk("disarmed", {16'h0, curr_set}, 32'h0aaa);
        wr(`OIP_A_CMD, 32'h2);
        wr(`OIP_A_CMD, 32'h4);
        settle(1);
        chk("cmd_trig", {16'h0, curr_set}, 32'h0123);
        $display("test trigger finished");
        wr(`OIP_A_PORT, 32'h3);
        settle(1);
        chk("no_digio", {30'h0, pin2, pin1}, 32'h0);
        wr(`OIP_A_CTRL, 32'h18);
        settle(1);
        chk("port_ignored", {30'h0, pin2, pin1}, 32'h0);
        for (v = 4'h0; v < 4'h8; v++) begin
            @(posedge clk);
            p3_level <= ~v[0];
            wr(`OIP_A_PORT, {28'h0, v});
            settle(3);
            chk("port_pins", {29'h0, pin3_oe, pin2, pin1},
                {29'h0, ~v[2], v[1:0]});
            rd_chk("port_rd", `OIP_A_PORT,
                {29'h0, v[2] & ~v[0], v[1:0]});
        end
        xfer(1'b0, 8'h24, 32'h0);
        chk("bad_rd", rd, 32'h0);
        chk("bad_err", 32'(se), 32'h1);
        $display("test port finished");
        conclude();
    end
endmodule

// ---- core/oip_core.sv ----
`timescale 1ns/100ps
`include "oip_defines.svh"

module oip_core
    import oip_pkg::*;
#(
    parameter int unsigned P_PROT_DLY_CYC =
        `OIP_PROT_DLY_MS * (`OIP_CLK_HZ / 1000)
) (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_INHIBIT_INPUT_N,
    input  wire logic        I_TRIG,
    input  wire logic [15:0] I_MEAS_CURR,
    input  wire logic [15:0] I_MEAS_CURR2,
    input  wire logic [1:0]  I_NV_MODE,
    output logic             O_NV_WR,
    output logic      [1:0]  O_NV_MODE,
    output logic             O_OUT_EN,
    output logic      [15:0] O_CURR_SET,
    output logic      [15:0] O_AUX_CURRENT_SETPOINT,
    output logic             O_OVERCURRENT_FLAG,
    output logic             O_FAULT_INDICATOR_OUT,
    output logic             O_PIN1,
    output logic             O_PIN2,
    input  wire logic        I_PIN3,
    output logic             O_PIN3,
    output logic             O_PIN3_OE
);

    // ********************************
    // helper functions
    // ********************************
    function automatic oip_mode_t mode_dec(input logic [1:0] c);
        case (c)
            `OIP_MODE_LIVE:  mode_dec = OIP_LIVE;
            `OIP_MODE_LATCH: mode_dec = OIP_LATCH;
            default:         mode_dec = OIP_OFF;
        endcase
    endfunction

    function automatic logic [1:0] mode_enc(input oip_mode_t m);
        case (m)
            OIP_LIVE:  mode_enc = `OIP_MODE_LIVE;
            OIP_LATCH: mode_enc = `OIP_MODE_LATCH;
            default:   mode_enc = `OIP_MODE_OFF;
        endcase
    endfunction

    // constant current when measured current reaches the limit
    function automatic logic at_limit(input logic [15:0] meas,
                                      input logic [15:0] lim);
        at_limit = (meas >= lim);
    endfunction

    // status is mapped for reads; writes to it are dropped without error
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            `OIP_A_CTRL, `OIP_A_CMD, `OIP_A_STAT,
            `OIP_A_CURR, `OIP_A_CURR2, `OIP_A_CURRT,
            `OIP_A_CURR2T, `OIP_A_PORT, `OIP_A_DLY:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    endfunction

    // ********************************
    // register map
    // ********************************
    // CTRL   [1:0] inhibit mode, [2] overcurrent enable,
    //        [3] digital i/o port use, [4] output on request
    // CMD    write only: [0] protection clear, [1] arm, [2] trigger
    // STAT   read only: [0] output enable, [1] overcurrent flag,
    //        [2] inhibit latch, [3] armed, [4] recorded constant
    //        current, [5] inhibit active, [6] raw constant current
    // CURR   active main setpoint, bits 15:0
    // CURR2  active auxiliary setpoint, bits 15:0
    // CURRT  pending main setpoint, moved on an armed trigger
    // CURR2T pending auxiliary setpoint, moved on the same trigger
    // PORT   [1:0] pin 1 and 2 data, [2] pin 3 as input;
    //        reads return the synchronised pin 3 level in bit 2
    // DLY    constant-current recording delay in clock cycles
    // unmapped offsets answer with an error and read as zero

    // ********************************
    // state
    // ********************************
    // delay reset value follows the clock rate; benches may shorten it
    localparam logic [31:0] DLY_RST = 32'(P_PROT_DLY_CYC);

    localparam oip_state_t ST_RST = '{
        mode:       OIP_OFF,
        nv_ld:      1'b1,
        nv_wr:      1'b0,
        nv_mode:    `OIP_MODE_OFF,
        ocp_en:     1'b0,
        digio:      1'b0,
        out_req:    1'b0,
        out_en:     1'b0,
        curr:       `OIP_CURR_RST,
        curr2:      `OIP_CURR_RST,
        curr_trig:  `OIP_CURR_RST,
        curr2_trig: `OIP_CURR_RST,
        port_data:  `OIP_PORT_RST,
        pin3_in:    1'b0,
        inh_s1:     1'b1,
        inh_s2:     1'b1,
        p3_s1:      1'b0,
        p3_s2:      1'b0,
        inh_latch:  1'b0,
        oc_flag:    1'b0,
        armed:      1'b0,
        dly_cnt:    32'h0,
        dly_val:    DLY_RST,
        prdata:     32'h0,
        pslverr:    1'b0
    };

    oip_state_t st_reg;
    oip_state_t st_next;

    logic inh_act;
    logic cc_raw;
    logic cc_rec;
    logic wr;
    logic clr_cmd;
    logic arm_cmd;
    logic trig_evt;
    logic chg;
    logic clr_ok;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_next = st_reg;
        st_next.nv_wr = 1'b0;

        // two-stage synchronisers; stage one feeds only stage two
        st_next.inh_s1 = I_INHIBIT_INPUT_N;
        st_next.inh_s2 = st_reg.inh_s1;
        st_next.p3_s1 = I_PIN3;
        st_next.p3_s2 = st_reg.p3_s1;

        // stored mode is reloaded once after reset release
        if (st_reg.nv_ld) begin
            st_next.mode = mode_dec(I_NV_MODE);
            st_next.nv_ld = 1'b0;
        end

        // inhibit pin is active low
        inh_act = ~st_reg.inh_s2;
        cc_raw = at_limit(I_MEAS_CURR, st_reg.curr)
               | at_limit(I_MEAS_CURR2, st_reg.curr2);
        // the raw state still blocks a clear while the delay runs
        cc_rec = cc_raw & (st_reg.dly_cnt == 32'h0);

        wr = I_PSEL & I_PENABLE & I_PWRITE;
        clr_cmd = wr & (I_PADDR == `OIP_A_CMD)
                & I_PWDATA[`OIP_CMD_CLR];
        arm_cmd = wr & (I_PADDR == `OIP_A_CMD)
                & I_PWDATA[`OIP_CMD_ARM];
        trig_evt = st_reg.armed
                 & (I_TRIG | (wr & (I_PADDR == `OIP_A_CMD)
                 & I_PWDATA[`OIP_CMD_TRIG]));

        // ****************************
        // register writes
        // ****************************
        if (wr) begin
            case (I_PADDR)
                `OIP_A_CTRL: begin
                    st_next.mode = mode_dec(
                        I_PWDATA[`OIP_CTRL_MODE +: 2]);
                    st_next.nv_mode = I_PWDATA[`OIP_CTRL_MODE +: 2];
                    // each control write costs one store cycle of the cell
                    st_next.nv_wr = 1'b1;
                    st_next.ocp_en = I_PWDATA[`OIP_CTRL_OCP];
                    st_next.digio = I_PWDATA[`OIP_CTRL_DIO];
                    st_next.out_req = I_PWDATA[`OIP_CTRL_ON];
                end
                `OIP_A_CURR: begin
                    st_next.curr = I_PWDATA[15:0];
                end
                `OIP_A_CURR2: begin
                    st_next.curr2 = I_PWDATA[15:0];
                end
                `OIP_A_CURRT: begin
                    st_next.curr_trig = I_PWDATA[15:0];
                end
                `OIP_A_CURR2T: begin
                    st_next.curr2_trig = I_PWDATA[15:0];
                end
                `OIP_A_PORT: begin
                    // ignored while the port serves another function
                    if (st_reg.digio) begin
                        st_next.port_data = I_PWDATA[1:0];
                        st_next.pin3_in = I_PWDATA[`OIP_PORT_DIR];
                    end
                end
                `OIP_A_DLY: begin
                    st_next.dly_val = I_PWDATA;
                end
                default: begin
                end
            endcase
        end

        // ****************************
        // trigger
        // ****************************
        // trigger beats a same-cycle write of the active setpoint
        // arming is spent by the first trigger, so a held input acts once
        if (trig_evt) begin
            st_next.curr = st_reg.curr_trig;
            st_next.curr2 = st_reg.curr2_trig;
            st_next.armed = 1'b0;
        end
        if (arm_cmd) begin
            st_next.armed = 1'b1;
        end

        // ****************************
        // protection
        // ****************************
        clr_ok = ~inh_act & ~cc_raw;
        if (clr_cmd && clr_ok) begin
            st_next.inh_latch = 1'b0;
            st_next.oc_flag = 1'b0;
        end
        // sets come after the clear so a new fault is never lost
        if (st_reg.mode == OIP_LATCH && inh_act) begin
            st_next.inh_latch = 1'b1;
        end
        if (st_reg.ocp_en && cc_rec && st_reg.out_en) begin
            st_next.oc_flag = 1'b1;
        end

        // any programmed output change restarts the delay window
        chg = trig_evt | clr_cmd
            | (wr & ((I_PADDR == `OIP_A_CURR)
            | (I_PADDR == `OIP_A_CURR2)
            | (I_PADDR == `OIP_A_CTRL)));
        if (chg) begin
            st_next.dly_cnt = st_reg.dly_val;
        end else if (st_reg.dly_cnt != 32'h0) begin
            st_next.dly_cnt = st_reg.dly_cnt - 32'h1;
        end

        // out_req is never touched by faults, so clearing restores it
        // inhibit terms read the second synchroniser stage only
        st_next.out_en = st_next.out_req & ~st_next.oc_flag
            & ~((st_next.mode == OIP_LATCH)
                & st_next.inh_latch)
            & ~((st_next.mode == OIP_LIVE)
                & inh_act);

        // ****************************
        // read data, caught in setup
        // ****************************
        if (I_PSEL && !I_PENABLE) begin
            st_next.pslverr = ~mapped(I_PADDR);
            st_next.prdata = 32'h0;
            if (!I_PWRITE) begin
                case (I_PADDR)
                    `OIP_A_CTRL: begin
                        st_next.prdata[`OIP_CTRL_MODE +: 2] =
                            mode_enc(st_reg.mode);
                        st_next.prdata[`OIP_CTRL_OCP] = st_reg.ocp_en;
                        st_next.prdata[`OIP_CTRL_DIO] = st_reg.digio;
                        st_next.prdata[`OIP_CTRL_ON] = st_reg.out_req;
                    end
                    `OIP_A_STAT: begin
                        st_next.prdata[6:0] = {cc_raw, inh_act,
                            cc_rec, st_reg.armed, st_reg.inh_latch,
                            st_reg.oc_flag, st_reg.out_en};
                    end
                    `OIP_A_CURR: begin
                        st_next.prdata[15:0] = st_reg.curr;
                    end
                    `OIP_A_CURR2: begin
                        st_next.prdata[15:0] = st_reg.curr2;
                    end
                    `OIP_A_CURRT: begin
                        st_next.prdata[15:0] = st_reg.curr_trig;
                    end
                    `OIP_A_CURR2T: begin
                        st_next.prdata[15:0] = st_reg.curr2_trig;
                    end
                    `OIP_A_PORT: begin
                        // bit 2 is the pin level, not the direction bit
                        st_next.prdata[2:0] = {st_reg.p3_s2,
                            st_reg.port_data};
                    end
                    `OIP_A_DLY: begin
                        st_next.prdata = st_reg.dly_val;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ********************************
    // state register
    // ********************************
    // asynchronous reset loads constants only
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // zero wait states: every access completes in its first cycle
    assign O_PREADY = 1'b1;
    assign O_PRDATA = st_reg.prdata;
    assign O_PSLVERR = st_reg.pslverr & I_PSEL & I_PENABLE;

    assign O_NV_WR = st_reg.nv_wr;
    assign O_NV_MODE = st_reg.nv_mode;
    assign O_OUT_EN = st_reg.out_en;
    assign O_CURR_SET = st_reg.curr;
    assign O_AUX_CURRENT_SETPOINT = st_reg.curr2;
    assign O_OVERCURRENT_FLAG = st_reg.oc_flag;
    assign O_FAULT_INDICATOR_OUT = st_reg.oc_flag | st_reg.inh_latch;

    // pins idle low when the port is not in digital i/o use
    assign O_PIN1 = st_reg.digio & st_reg.port_data[0];
    assign O_PIN2 = st_reg.digio & st_reg.port_data[1];
    // pin 3 drives low whenever it is an output; no data bit sets its level
    assign O_PIN3 = 1'b0;
    assign O_PIN3_OE = st_reg.digio & ~st_reg.pin3_in;

endmodule

// ---- core/oip_defines.svh ----
`ifndef OIP_DEFINES_SVH
`define OIP_DEFINES_SVH

// ********************************
// register byte offsets
// ********************************
`define OIP_A_CTRL    8'h00
`define OIP_A_CMD     8'h04
`define OIP_A_STAT    8'h08
`define OIP_A_CURR    8'h0c
`define OIP_A_CURR2   8'h10
`define OIP_A_CURRT   8'h14
`define OIP_A_CURR2T  8'h18
`define OIP_A_PORT    8'h1c
`define OIP_A_DLY     8'h20

// ********************************
// field positions
// ********************************
`define OIP_CTRL_MODE 0
`define OIP_CTRL_OCP  2
`define OIP_CTRL_DIO  3
`define OIP_CTRL_ON   4
`define OIP_CMD_CLR   0
`define OIP_CMD_ARM   1
`define OIP_CMD_TRIG  2
`define OIP_PORT_DIR  2

// ********************************
// encodings and reset values
// ********************************
`define OIP_MODE_OFF   2'h0
`define OIP_MODE_LIVE  2'h1
`define OIP_MODE_LATCH 2'h2
`define OIP_CURR_RST   16'h1999
`define OIP_PORT_RST   2'h0

// ********************************
// timing
// ********************************
`define OIP_CLK_HZ       25000000
`define OIP_PROT_DLY_MS  80

`endif

// ---- core/oip_pkg.sv ----
package oip_pkg;

    typedef enum logic [2:0] {
        OIP_OFF   = 3'b001,
        OIP_LIVE  = 3'b010,
        OIP_LATCH = 3'b100
    } oip_mode_t;

    typedef struct packed {
        oip_mode_t   mode;
        logic        nv_ld;
        logic        nv_wr;
        logic [1:0]  nv_mode;
        logic        ocp_en;
        logic        digio;
        logic        out_req;
        logic        out_en;
        logic [15:0] curr;
        logic [15:0] curr2;
        logic [15:0] curr_trig;
        logic [15:0] curr2_trig;
        logic [1:0]  port_data;
        logic        pin3_in;
        logic        inh_s1;
        logic        inh_s2;
        logic        p3_s1;
        logic        p3_s2;
        logic        inh_latch;
        logic        oc_flag;
        logic        armed;
        logic [31:0] dly_cnt;
        logic [31:0] dly_val;
        logic [31:0] prdata;
        logic        pslverr;
    } oip_state_t;

endpackage
